/* File: mdc_ctrl.sv */
// Controller that runs the multiply/divide unit through its register port.
// Assumes the unit shares clk and answers a read in the cycle after the strobe.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_defs.svh"

module mdc_ctrl
  import mdc_pkg::*;
#(
  parameter int WAIT_MARGIN = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Software register port.
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Interrupt and power hold.
  output logic irq,
  output logic hold_awake,
  // Device register port.
  output logic [2:0] dev_addr,
  output logic [7:0] dev_wdata,
  output logic dev_we,
  output logic dev_re,
  input wire logic [7:0] dev_rdata
);

  mdc_state_t state;
  mdc_op_t op;
  logic [2:0] step;
  logic [4:0] cnt;
  logic [31:0] opa;
  logic [15:0] opb;
  logic [7:0] res [0:5];
  logic dev_err;
  logic dev_ov;
  logic [`MDC_EV_W-1:0] ev_stat;
  logic [`MDC_EV_W-1:0] ev_en;
  logic [`MDC_EV_W-1:0] ev_set;
  logic busy;
  logic start_req;
  mdc_op_t req_op;

  // Register index written at each step of an operation.
  function automatic logic [2:0] wr_reg(input mdc_op_t o, input logic [2:0] s);
    logic [2:0] r;
    r = s;
    case (o)
      MDC_OP_DIV32: r = s; // RL3
      MDC_OP_DIV16: begin
        case (s)
          3'h0: r = `MDC_DEV_DATA0; // RL4
          3'h1: r = `MDC_DEV_DATA1;
          3'h2: r = `MDC_DEV_DATA4;
          default: r = `MDC_DEV_DATA5;
        endcase
      end
      MDC_OP_MUL: begin
        case (s)
          3'h0: r = `MDC_DEV_DATA0; // RL5
          3'h1: r = `MDC_DEV_DATA4;
          3'h2: r = `MDC_DEV_DATA1;
          default: r = `MDC_DEV_DATA5;
        endcase
      end
      default: r = s;
    endcase
    return r;
  endfunction : wr_reg

  // Register index read at each step of the result readout.
  function automatic logic [2:0] rd_reg(input mdc_op_t o, input logic [2:0] s);
    logic [2:0] r;
    r = s;
    case (o)
      MDC_OP_DIV16: begin
        case (s)
          3'h0: r = `MDC_DEV_DATA0; // RL15
          3'h1: r = `MDC_DEV_DATA1;
          3'h2: r = `MDC_DEV_DATA4;
          default: r = `MDC_DEV_DATA5;
        endcase
      end
      default: r = s; // RL14 RL16
    endcase
    return r;
  endfunction : rd_reg

  // Index of the last byte step each way for an operation (one less than the bytes moved).
  function automatic logic [2:0] last_step(input mdc_op_t o);
    return (o == MDC_OP_DIV32) ? 3'h5 : 3'h3;
  endfunction : last_step

  // Operand byte that belongs in a device data register.
  function automatic logic [7:0] reg_byte(input logic [2:0] r, input logic [31:0] a, input logic [15:0] b);
    logic [7:0] v;
    v = 8'h00;
    case (r)
      `MDC_DEV_DATA0: v = a[7:0]; // RL2
      `MDC_DEV_DATA1: v = a[15:8];
      `MDC_DEV_DATA2: v = a[23:16];
      `MDC_DEV_DATA3: v = a[31:24];
      `MDC_DEV_DATA4: v = b[7:0];
      `MDC_DEV_DATA5: v = b[15:8];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_byte

  // Wait after the final operand write before the unit may be touched.
  function automatic logic [4:0] calc_wait(input mdc_op_t o);
    logic [4:0] t;
    case (o)
      MDC_OP_DIV32: t = `MDC_T_DIV32; // RL8
      MDC_OP_DIV16: t = `MDC_T_DIV16;
      default: t = `MDC_T_MUL;
    endcase
    return t + 5'(WAIT_MARGIN);
  endfunction : calc_wait

  assign busy = (state != MDC_ST_IDLE);
  assign req_op = mdc_op_t'(wdata[`MDC_CTRL_OP_LSB+1:`MDC_CTRL_OP_LSB]);
  assign start_req = wr && (addr == `MDC_REG_CTRL) && wdata[`MDC_CTRL_START_BIT];

  // Operand registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opa <= 32'h0000_0000;
      opb <= 16'h0000;
    end else if (wr && !busy) begin
      if (addr == `MDC_REG_OPA) begin
        opa <= wdata;
      end
      if (addr == `MDC_REG_OPB) begin
        opb <= wdata[15:0];
      end
    end
  end

  // Sequencer driving the device port.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= MDC_ST_IDLE;
      op <= MDC_OP_DIV32;
      step <= 3'h0;
      cnt <= 5'h00;
      dev_addr <= `MDC_DEV_DATA0;
      dev_wdata <= 8'h00;
      dev_we <= 1'b0;
      dev_re <= 1'b0;
    end else begin
      dev_we <= 1'b0;
      dev_re <= 1'b0;
      case (state)
        MDC_ST_IDLE: begin
          if (start_req && req_op != MDC_OP_BAD) begin
            op <= req_op;
            step <= 3'h0;
            state <= MDC_ST_WR;
          end
        end
        MDC_ST_WR: begin
          // Writes never deviate from a valid order, so the unit never abandons one.
          dev_we <= 1'b1; // RL6 RL19
          dev_addr <= wr_reg(op, step);
          dev_wdata <= reg_byte(wr_reg(op, step), opa, opb);
          if (step == last_step(op)) begin
            cnt <= calc_wait(op); // RL8
            state <= MDC_ST_WAIT;
          end else begin
            step <= step + 3'h1;
          end
        end
        MDC_ST_WAIT: begin
          if (cnt == 5'h00) begin
            dev_re <= 1'b1; // RL13 RL10
            dev_addr <= `MDC_DEV_STATUS;
            state <= MDC_ST_RDST;
          end else begin
            cnt <= cnt - 5'h01; // RL9
          end
        end
        MDC_ST_RDST: state <= MDC_ST_CAPST;
        MDC_ST_CAPST: begin
          if (dev_rdata[`MDC_DEV_ERR_BIT] || dev_rdata[`MDC_DEV_OV_BIT]) begin
            state <= MDC_ST_DONE; // RL13
          end else begin
            step <= 3'h0;
            dev_re <= 1'b1;
            dev_addr <= rd_reg(op, 3'h0);
            state <= MDC_ST_RDRES;
          end
        end
        MDC_ST_RDRES: state <= MDC_ST_CAPRES;
        MDC_ST_CAPRES: begin
          if (step == last_step(op)) begin
            state <= MDC_ST_DONE;
          end else begin
            step <= step + 3'h1;
            dev_re <= 1'b1; // RL17
            dev_addr <= rd_reg(op, step + 3'h1);
            state <= MDC_ST_RDRES;
          end
        end
        MDC_ST_DONE: state <= MDC_ST_IDLE;
        default: state <= MDC_ST_IDLE;
      endcase
    end
  end

  // Device status capture.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_err <= 1'b0;
      dev_ov <= 1'b0;
    end else if (state == MDC_ST_CAPST) begin
      dev_err <= dev_rdata[`MDC_DEV_ERR_BIT]; // RL9
      dev_ov <= dev_rdata[`MDC_DEV_OV_BIT]; // RL11 RL12
    end
  end

  // Result bytes, stored at the index of the register they came from.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 6; i++) begin
        res[i] <= 8'h00;
      end
    end else if (state == MDC_ST_WR && step == 3'h0) begin
      for (int i = 0; i < 6; i++) begin
        res[i] <= 8'h00;
      end
    end else if (state == MDC_ST_CAPRES) begin
      res[rd_reg(op, step)] <= dev_rdata; // RL14 RL15 RL16
    end
  end

  // Events for the interrupt status.
  always_comb begin
    ev_set = '0;
    ev_set[`MDC_EV_DONE] = (state == MDC_ST_DONE);
    ev_set[`MDC_EV_ERR] = (state == MDC_ST_CAPST) && dev_rdata[`MDC_DEV_ERR_BIT];
    ev_set[`MDC_EV_OV] = (state == MDC_ST_CAPST) && dev_rdata[`MDC_DEV_OV_BIT];
    ev_set[`MDC_EV_REJ] = start_req && (busy || req_op == MDC_OP_BAD);
  end

  // Sticky status, set wins over clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_stat <= '0;
    end else if (wr && addr == `MDC_REG_IRQ_CLR) begin
      ev_stat <= (ev_stat & ~wdata[`MDC_EV_W-1:0]) | ev_set;
    end else begin
      ev_stat <= ev_stat | ev_set;
    end
  end

  // Interrupt enable.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_en <= '0;
    end else if (wr && addr == `MDC_REG_IRQ_EN) begin
      ev_en <= wdata[`MDC_EV_W-1:0];
    end
  end

  // Interrupt and sleep hold outputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
      hold_awake <= 1'b0;
    end else begin
      irq <= |(ev_stat & ev_en);
      hold_awake <= busy || (start_req && req_op != MDC_OP_BAD); // RL18
    end
  end

  // Register read port.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `MDC_REG_CTRL: rdata <= {29'h0000_0000, op, 1'b0};
        `MDC_REG_OPA: rdata <= opa;
        `MDC_REG_OPB: rdata <= {16'h0000, opb};
        `MDC_REG_STATUS: rdata <= {26'h000_0000, op, 1'b0, dev_ov, dev_err, busy};
        `MDC_REG_RESLO: rdata <= {res[3], res[2], res[1], res[0]};
        `MDC_REG_RESHI: rdata <= {16'h0000, res[5], res[4]};
        `MDC_REG_IRQ_STAT: rdata <= {28'h000_0000, ev_stat};
        `MDC_REG_IRQ_EN: rdata <= {28'h000_0000, ev_en};
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : mdc_ctrl
`default_nettype wire

/* File: mdc_defs.svh */
// Constants for the multiply/divide controller: device register indices,
// own register offsets, field positions, reset values and timing counts.
// Assumes the device is clocked by the same system clock as the controller.
// Operation
// RL1 - Unit multiplies 16x16 unsigned and divides 32/16 or 16/16 unsigned.
// RL2 - Each operand is written low byte first, then high byte.
// RL3 - Writing data registers 0 through 5 in order selects 32/16 division.
// RL4 - Writing registers 0, 1, 4, 5 only selects 16/16 division.
// RL5 - Writing registers 0, 4, 1, 5 only selects multiplication.
// RL6 - The write of data register 5 after a valid order starts the operation.
// RL7 - Unrelated activity between operand writes does not break the sequence.
// RL8 - Operation takes 17, 9 or 11 system clocks for div32, div16, multiply.
// RL9 - No data register access while running; doing so sets error bit 7.
// RL10 - Reading status after completion clears a set error flag.
// RL11 - Overflow bit 6 means product above FFFFH or zero divisor.
// RL12 - Overflow flag is updated at the end of every operation.
// RL13 - Software checks status after completion before reading the result.
// RL14 - After 32/16 division read quotient regs 0-3, then remainder regs 4-5.
// RL15 - After 16/16 division read quotient regs 0-1, then remainder regs 4-5.
// RL16 - After multiplication read the product low byte first from regs 0-3.
// RL17 - Unrelated activity between result reads keeps result and order intact.
// RL18 - No idle or sleep mode until the running operation has completed.
// RL19 - A write breaking every valid order abandons it; register 0 restarts.
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH

// Device register indices on the device port.
`define MDC_DEV_DATA0 3'h0
`define MDC_DEV_DATA1 3'h1
`define MDC_DEV_DATA2 3'h2
`define MDC_DEV_DATA3 3'h3
`define MDC_DEV_DATA4 3'h4
`define MDC_DEV_DATA5 3'h5
`define MDC_DEV_STATUS 3'h6

// Device status fields.
`define MDC_DEV_ERR_BIT 7
`define MDC_DEV_OV_BIT 6
`define MDC_DEV_STATUS_RST 8'h00

// Own register offsets.
`define MDC_REG_CTRL 4'h0
`define MDC_REG_OPA 4'h1
`define MDC_REG_OPB 4'h2
`define MDC_REG_STATUS 4'h3
`define MDC_REG_RESLO 4'h4
`define MDC_REG_RESHI 4'h5
`define MDC_REG_IRQ_STAT 4'h6
`define MDC_REG_IRQ_EN 4'h7
`define MDC_REG_IRQ_CLR 4'h8

// Control fields.
`define MDC_CTRL_START_BIT 0
`define MDC_CTRL_OP_LSB 1

// Interrupt event bits.
`define MDC_EV_DONE 0
`define MDC_EV_ERR 1
`define MDC_EV_OV 2
`define MDC_EV_REJ 3
`define MDC_EV_W 4

// Calculation times in system clock periods.
`define MDC_T_DIV32 5'h11
`define MDC_T_DIV16 5'h09
`define MDC_T_MUL 5'h0B

`endif

/* File: mdc_pkg.sv */
// Types for the multiply/divide controller.
// Assumes mdc_defs.svh supplies the constants.
package mdc_pkg;

  typedef enum logic [1:0] {
    MDC_OP_DIV32 = 2'b00,
    MDC_OP_DIV16 = 2'b01,
    MDC_OP_MUL = 2'b10,
    MDC_OP_BAD = 2'b11
  } mdc_op_t;

  typedef enum logic [2:0] {
    MDC_ST_IDLE = 3'b000,
    MDC_ST_WR = 3'b001,
    MDC_ST_WAIT = 3'b010,
    MDC_ST_RDST = 3'b011,
    MDC_ST_CAPST = 3'b100,
    MDC_ST_RDRES = 3'b101,
    MDC_ST_CAPRES = 3'b110,
    MDC_ST_DONE = 3'b111
  } mdc_state_t;

endpackage : mdc_pkg

/* File: mdc_checker.sv */
// Concurrent checks on the controller's device port and power hold output.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module mdc_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Software port.
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  // Power hold.
  input wire logic hold_awake,
  // Device port.
  input wire logic [2:0] dev_addr,
  input wire logic dev_we,
  input wire logic dev_re
);
  logic wr_seen;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Remembers whether the last device access was a write.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_seen <= 1'b0;
    end else if (dev_we || dev_re) begin
      wr_seen <= dev_we;
    end
  end
  start_awake_a: assert property (wr && addr == 4'h0 && wdata[0] && wdata[2:1] != 2'b11 && !hold_awake
    |=> hold_awake)
    else $error("no hold after start");
  first_wr_a: assert property ($rose(hold_awake) |=> dev_we && dev_addr == 3'h0)
    else $error("first write not reg 0");
  div32_order_a: assert property (dev_we && dev_addr == 3'h2 |=> dev_we && dev_addr == 3'h3
    ##1 dev_we && dev_addr == 3'h4)
    else $error("long divide order");
  div16_order_a: assert property (dev_we && dev_addr == 3'h1 && $past(dev_we) |=>
    dev_we && dev_addr inside {3'h2, 3'h4, 3'h5})
    else $error("short divide order");
  mul_order_a: assert property (dev_we && dev_addr == 3'h4 && $past(dev_addr) == 3'h0 |=>
    dev_we && dev_addr == 3'h1)
    else $error("multiply order");
  wait_quiet_a: assert property (dev_we && dev_addr == 3'h5 |=> (!dev_we && !dev_re) [*8])
    else $error("access while running");
  status_first_a: assert property (dev_re && wr_seen |-> dev_addr == 3'h6)
    else $error("result read before status");
  rd_lo_order_a: assert property (dev_re && dev_addr == 3'h0 |=> !dev_re ##1 dev_re && dev_addr == 3'h1)
    else $error("low result order");
  rd_hi_order_a: assert property (dev_re && dev_addr == 3'h4 |=> !dev_re ##1 dev_re && dev_addr == 3'h5)
    else $error("remainder order");
  long_div_c: cover property (dev_we && dev_addr == 3'h2);
  status_rd_c: cover property (dev_re && dev_addr == 3'h6);
  rem_rd_c: cover property (dev_re && dev_addr == 3'h5);
endmodule : mdc_checker
`default_nettype wire

/* File: mdc_dev_model.sv */
// Behavioural model of the multiply/divide unit behind its byte register port.
// Assumes it shares clk with the controller and answers a read one cycle later.
`timescale 1ns/100ps
`default_nettype none

module mdc_dev_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Device port.
  input wire logic [2:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_we,
  input wire logic dev_re,
  output logic [7:0] dev_rdata
);
  logic [7:0] r [6];
  logic [2:0] p32, p16, pm;
  logic [4:0] busy;
  logic [1:0] md;
  logic ef, ov;
  logic [31:0] dd, q;
  logic [15:0] dv;
  // Next place in a write order; register 0 restarts it.
  function automatic logic [2:0] nx(input logic [2:0] p, input logic [2:0] a, input logic [17:0] s);
    return a == s[3 * p +: 3] ? p + 3'd1 : {2'b00, a == 3'h0};
  endfunction : nx
  assign dv = {r[5], r[4]};
  assign dd = {md == 2'd0 ? {r[3], r[2]} : 16'h0000, r[1], r[0]};
  assign q = md == 2'd2 ? dd * dv : dd / dv;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {p32, p16, pm, busy, md, ef, ov} <= '0;
      dev_rdata <= 8'h00;
    end else begin
      dev_rdata <= ~dev_rdata;
      if (dev_re) dev_rdata <= dev_addr == 3'h6 ? {ef, ov, 6'h00} : r[dev_addr];
      if ((dev_we || dev_re) && dev_addr != 3'h6 && busy != 5'h0) ef <= 1'b1;
      if (dev_re && dev_addr == 3'h6 && busy == 5'h0) ef <= 1'b0;
      if (dev_we && dev_addr != 3'h6 && busy == 5'h0) begin
        r[dev_addr] <= dev_wdata;
        p32 <= nx(p32, dev_addr, {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0});
        p16 <= nx(p16, dev_addr, {6'h00, 3'h5, 3'h4, 3'h1, 3'h0});
        pm <= nx(pm, dev_addr, {6'h00, 3'h5, 3'h1, 3'h4, 3'h0});
        if (dev_addr == 3'h5) {p32, p16, pm} <= '0;
        if (dev_addr == 3'h5 && (p32 == 3'h5 || p16 == 3'h3 || pm == 3'h3)) begin
          busy <= p32 == 3'h5 ? 5'd17 : p16 == 3'h3 ? 5'd9 : 5'd11;
          md <= p32 == 3'h5 ? 2'd0 : p16 == 3'h3 ? 2'd1 : 2'd2;
        end
      end
      if (busy != 5'h0) busy <= busy - 5'h1;
      if (busy == 5'h1) begin
        {r[3], r[2], r[1], r[0]} <= q;
        if (md != 2'd2) {r[5], r[4]} <= 16'(dd % dv);
        ov <= md == 2'd2 ? q > 32'h0000_FFFF : dv == 16'h0000;
      end
    end
  end
endmodule : mdc_dev_model
`default_nettype wire

/* File: mdc_ctrl_tb_top.sv */
// Register-level testbench of the controller with the device model behind it.
// Assumes mdc_ctrl, mdc_dev_model and mdc_checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_defs.svh"
bind mdc_ctrl mdc_checker chk_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .hold_awake(hold_awake), .dev_addr(dev_addr), .dev_we(dev_we), .dev_re(dev_re));

module mdc_ctrl_tb_top;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic irq, hold_awake, dev_we, dev_re;
  logic [2:0] dev_addr;
  logic [7:0] dev_wdata, dev_rdata;
  int compares = 0, miscompares = 0;
  logic [1:0] op_t [5] = '{2'd0, 2'd1, 2'd2, 2'd1, 2'd2};
  logic [31:0] a_t [5] = '{32'h1234_5678, 32'h0000_BEEF, 32'h0000_00F0, 32'h0000_0777, 32'h0000_1000};
  logic [31:0] b_t [5] = '{32'h0000_0123, 32'h0000_0045, 32'h0000_0011, 32'h0000_0000, 32'h0000_0100};
  always #5 clk = ~clk;
  mdc_ctrl dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .hold_awake(hold_awake), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_we(dev_we),
    .dev_re(dev_re), .dev_rdata(dev_rdata));
  mdc_dev_model dev (.clk(clk), .arst_n(arst_n), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_we(dev_we), .dev_re(dev_re), .dev_rdata(dev_rdata));
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  initial begin
    logic [31:0] d, lo, hi;
    logic ov;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(`MDC_REG_STATUS, d);
    chk(d, 32'h0000_0000);
    wr_reg(`MDC_REG_CTRL, 32'h0000_0007);
    rd_reg(`MDC_REG_IRQ_STAT, d);
    chk(d, 32'h0000_0008);
    rd_reg(4'hF, d);
    chk({d[31:1], irq}, 32'h0000_0000);
    wr_reg(`MDC_REG_IRQ_CLR, 32'h0000_000F);
    $display("test reject done");
    for (int i = 0; i < 5; i++) begin
      wr_reg(`MDC_REG_OPA, a_t[i]);
      wr_reg(`MDC_REG_OPB, b_t[i]);
      wr_reg(`MDC_REG_IRQ_EN, 32'h0000_000F);
      wr_reg(`MDC_REG_CTRL, {29'h0, op_t[i], 1'b1});
      wr_reg(`MDC_REG_CTRL, {29'h0, op_t[i], 1'b1});
      @(negedge clk);
      chk({31'h0, hold_awake}, 32'h0000_0001);
      d = 32'h0000_0001;
      for (int n = 0; n < 60 && d[0] !== 1'b0; n++) rd_reg(`MDC_REG_STATUS, d);
      ov = op_t[i] == 2'd2 ? 32'(a_t[i][15:0]) * b_t[i][15:0] > 32'h0000_FFFF : b_t[i][15:0] == 16'h0000;
      lo = op_t[i] == 2'd0 ? a_t[i] / b_t[i] : op_t[i] == 2'd1 ? a_t[i] / b_t[i] : a_t[i] * b_t[i];
      hi = op_t[i] == 2'd2 ? 32'h0000_0000 : a_t[i] % b_t[i];
      if (ov) lo = 32'h0000_0000;
      if (ov) hi = 32'h0000_0000;
      chk(d, {26'h0, op_t[i], 1'b0, ov, 2'b00});
      chk({31'h0, hold_awake}, 32'h0000_0000);
      rd_reg(`MDC_REG_RESLO, d);
      chk(d, lo);
      rd_reg(`MDC_REG_RESHI, d);
      chk(d, hi);
      rd_reg(`MDC_REG_IRQ_STAT, d);
      chk(d, {28'h0, 1'b1, ov, 2'b01});
      chk({31'h0, irq}, 32'h0000_0001);
      wr_reg(`MDC_REG_IRQ_CLR, 32'h0000_000F);
      rd_reg(`MDC_REG_IRQ_STAT, d);
      chk({d[31:1], irq}, 32'h0000_0000);
      $display("test %0d done", i);
    end
    wrap_up();
  end
endmodule : mdc_ctrl_tb_top
`default_nettype wire
